// file: hdl/clks_params.svh
`ifndef CLKS_PARAMS_SVH
`define CLKS_PARAMS_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define CLKS_ADDR_W           3
`define CLKS_ADDR_MODE        3'h0
`define CLKS_ADDR_TRIM        3'h1
`define CLKS_ADDR_T3C         3'h2
`define CLKS_ADDR_STATUS      3'h3

// ---------------------------------------------------------------
// Clock mode fields and values
// ---------------------------------------------------------------
`define CLKS_MODE_FAST_EN_BIT 4
`define CLKS_MODE_SLOW_EN_BIT 2
`define CLKS_MODE_SEL_MSB     7
`define CLKS_MODE_SEL_LSB     5
`define CLKS_MODE_SUB_BIT     3
`define CLKS_SEL_SLOW         3'h7
`define CLKS_SEL_LOW          3'h0
`define CLKS_SEL_DIV8         3'h1
`define CLKS_SEL_DIV32        3'h3
`define CLKS_MODE_DIV4        8'h14
`define CLKS_MODE_DIV8        8'h3c
`define CLKS_MODE_DIV16       8'h1c
`define CLKS_MODE_DIV32       8'h7c
`define CLKS_MODE_SLOW        8'he4
`define CLKS_MODE_RST_SLOW    8'hf4
`define CLKS_MODE_RST_DIV64   8'h54

// ---------------------------------------------------------------
// Divider taps: bit k of the counter is fast/2^(k+1)
// ---------------------------------------------------------------
`define CLKS_DIV_W            6
`define CLKS_TAP_DIV4         3'h1
`define CLKS_TAP_DIV8         3'h2
`define CLKS_TAP_DIV16        3'h3
`define CLKS_TAP_DIV32        3'h4
`define CLKS_TAP_DIV64        3'h5

// ---------------------------------------------------------------
// Calibration option straps
// ---------------------------------------------------------------
`define CLKS_CAL_NONE         3'h0
`define CLKS_CAL_DIV4         3'h1
`define CLKS_CAL_DIV8         3'h2
`define CLKS_CAL_DIV16        3'h3
`define CLKS_CAL_DIV32        3'h4
`define CLKS_CAL_SLOW         3'h5

// ---------------------------------------------------------------
// Oscillator model and reset values
// ---------------------------------------------------------------
`define CLKS_STEP_W           16
`define CLKS_SLOW_STEP        16'h0200
`define CLKS_ULTRA_STEP       16'h0080
`define CLKS_TRIM_RESET       8'h80
`define CLKS_T3C_RESET        1'h1
`define CLKS_SETTLE_CYCLES    3'h4
`define CLKS_STAT_W           6

`endif

// file: hdl/clks_pkg.sv
package clks_pkg;
   typedef enum logic [1:0] {
      CLKS_BOOT_SETTLE,
      CLKS_BOOT_APPLY,
      CLKS_BOOT_RUN
   } clks_boot_t;

   typedef enum logic [2:0] {
      CLKS_SRC_DIV4,
      CLKS_SRC_DIV8,
      CLKS_SRC_DIV16,
      CLKS_SRC_DIV32,
      CLKS_SRC_DIV64,
      CLKS_SRC_SLOW
   } clks_src_t;
endpackage

// file: hdl/clks_osc_if.sv
`timescale 1ns/1ps
`include "clks_params.svh"
interface clks_osc_if;
   logic                      enable;
   logic [`CLKS_STEP_W-1:0]   step;
   logic                      tick;

   modport osc (input enable, input step, output tick);
   modport ctl (output enable, output step, input tick);
endinterface

// file: hdl/clks_osc.sv
`timescale 1ns/1ps
`include "clks_params.svh"
// ---------------------------------------------------------------
// Oscillator model: phase accumulator, one tick per wrap
// ---------------------------------------------------------------
module clks_osc (
   // Clock and reset
   input  wire logic     clk,
   input  wire logic     reset_n,
   // Control and tick
   clks_osc_if.osc       osc
);
   logic [`CLKS_STEP_W-1:0] acc_q;
   logic [`CLKS_STEP_W:0]   sum;
   logic                    tick_q;

   assign sum      = {1'b0, acc_q} + {1'b0, osc.step};
   assign osc.tick = tick_q;

   // Stopped oscillator holds its phase and gives no edges
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         acc_q  <= osc.enable ? sum[`CLKS_STEP_W-1:0] : acc_q;
         tick_q <= osc.enable & sum[`CLKS_STEP_W];
      end
   end
endmodule

// file: hdl/clks_sync.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Three-stage input synchroniser, accepted when stages agree
// ---------------------------------------------------------------
module clks_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] out_q;

   assign dout = out_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else begin
         s1_q  <= din;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= (s2_q == s3_q) ? s3_q : out_q;
      end
   end
endmodule

// file: hdl/clks_ctrl.sv
// Summary of operation
// - All three RC oscillators run after boot, except fast after a calibrated slow boot
// - Trim register tunes fast oscillator frequency
// - Core clock: divided fast or slow oscillator
// - Mode 14h selects fast divided by four
// - Mode 3Ch selects fast divided by eight
// - Mode 1Ch selects fast divided by sixteen
// - Mode 7Ch selects fast divided by thirty-two
// - Mode E4h selects slow, fast off
// - Mode write switches core clock immediately
// - Calibrated boot: watchdog off, slow on, pin in
// - Uncalibrated boot: reset mode, watchdog on
// - Trim found once, only reloaded at boot
// - Mode bit 4 fast, bit 2 slow enable
// - Ultra-slow on by default, timer bit 0
`timescale 1ns/1ps
`include "clks_params.svh"
module clks_ctrl (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // Register port
   input  wire logic [`CLKS_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rdata,
   // Boot straps from program memory options
   input  wire logic [2:0]              cal_option,
   input  wire logic [7:0]              cal_trim_value,
   input  wire logic                    boot_fast_option,
   // Clock outputs
   output logic                         core_clock,
   output logic                         ultra_slow_tick,
   // Oscillator and boot status
   output logic                         fast_rc_oscillator_on,
   output logic                         slow_rc_oscillator_on,
   output logic                         ultra_slow_rc_oscillator_on,
   output logic                         watchdog_enable,
   output logic                         port_a_pin_five_input,
   output logic                         boot_done
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   clks_pkg::clks_boot_t      boot_q;
   clks_pkg::clks_boot_t      boot_d;
   clks_pkg::clks_src_t       src;
   logic [7:0]                mode_q;
   logic [7:0]                mode_d;
   logic [7:0]                trim_q;
   logic [7:0]                trim_d;
   logic                      t3c_q;
   logic                      wdt_q;
   logic                      wdt_d;
   logic                      pin_in_q;
   logic [2:0]                settle_q;
   logic [7:0]                rdata_q;
   logic [7:0]                rdata_d;
   logic [`CLKS_DIV_W-1:0]    div_q;
   logic                      slow_phase_q;
   logic                      core_q;
   logic                      core_d;
   logic [2:0]                cal_s;
   logic [7:0]                trim_s;
   logic                      fast_opt_s;
   logic                      cal_active;
   logic [7:0]                boot_mode;
   logic                      wr_mode;
   logic                      wr_trim;
   logic                      wr_t3c;
   logic [2:0]                mode_sel;
   logic                      mode_sub;
   logic                      sel_slow;
   logic [2:0]                tap;
   logic                      fast_en;
   logic                      slow_en;
   logic                      div_clk;
   logic [`CLKS_STAT_W-1:0]   status;

   clks_osc_if fast_if ();
   clks_osc_if slow_if ();
   clks_osc_if ultra_if ();

   // ---------------------------------------------------------------
   // Strap synchronisers
   // ---------------------------------------------------------------
   // Straps are quiet levels, but they still cross in from pins
   clks_sync #(
      .WIDTH (12)
   ) u_strap_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .din     ({cal_option, cal_trim_value, boot_fast_option}),
      .dout    ({cal_s, trim_s, fast_opt_s})
   );

   // ---------------------------------------------------------------
   // Oscillators
   // ---------------------------------------------------------------
   assign fast_en = mode_q[`CLKS_MODE_FAST_EN_BIT];
   assign slow_en = mode_q[`CLKS_MODE_SLOW_EN_BIT];

   // Trim sets the fast phase step directly
   assign fast_if.enable  = fast_en;
   assign fast_if.step    = {1'b0, trim_q, 7'h00};
   assign slow_if.enable  = slow_en;
   assign slow_if.step    = `CLKS_SLOW_STEP;
   assign ultra_if.enable = t3c_q;
   assign ultra_if.step   = `CLKS_ULTRA_STEP;

   clks_osc u_fast (
      .clk     (clk),
      .reset_n (reset_n),
      .osc     (fast_if.osc)
   );

   clks_osc u_slow (
      .clk     (clk),
      .reset_n (reset_n),
      .osc     (slow_if.osc)
   );

   clks_osc u_ultra (
      .clk     (clk),
      .reset_n (reset_n),
      .osc     (ultra_if.osc)
   );

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   assign mode_sel = mode_q[`CLKS_MODE_SEL_MSB:`CLKS_MODE_SEL_LSB];
   assign mode_sub = mode_q[`CLKS_MODE_SUB_BIT];
   assign sel_slow = (mode_sel == `CLKS_SEL_SLOW);

   always_comb begin
      if (sel_slow) begin
         src = clks_pkg::CLKS_SRC_SLOW;
      end else if (mode_sel == `CLKS_SEL_LOW) begin
         src = mode_sub ? clks_pkg::CLKS_SRC_DIV16
                        : clks_pkg::CLKS_SRC_DIV4;
      end else if (mode_sel == `CLKS_SEL_DIV8) begin
         src = clks_pkg::CLKS_SRC_DIV8;
      end else if (mode_sel == `CLKS_SEL_DIV32) begin
         src = clks_pkg::CLKS_SRC_DIV32;
      end else begin
         src = clks_pkg::CLKS_SRC_DIV64;
      end
   end

   always_comb begin
      unique case (src)
         clks_pkg::CLKS_SRC_DIV4:  tap = `CLKS_TAP_DIV4;
         clks_pkg::CLKS_SRC_DIV8:  tap = `CLKS_TAP_DIV8;
         clks_pkg::CLKS_SRC_DIV16: tap = `CLKS_TAP_DIV16;
         clks_pkg::CLKS_SRC_DIV32: tap = `CLKS_TAP_DIV32;
         clks_pkg::CLKS_SRC_DIV64: tap = `CLKS_TAP_DIV64;
         clks_pkg::CLKS_SRC_SLOW:  tap = `CLKS_TAP_DIV64;
         default:                  tap = `CLKS_TAP_DIV64;
      endcase
   end

   // ---------------------------------------------------------------
   // Divider and output mux
   // ---------------------------------------------------------------
   // No glitch guard: a switch may cut a phase short, as the
   // selection takes effect at once
   assign div_clk = div_q[tap];
   assign core_d  = sel_slow ? slow_phase_q : div_clk;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q        <= '0;
         slow_phase_q <= 1'b0;
         core_q       <= 1'b0;
      end else begin
         div_q        <= div_q + `CLKS_DIV_W'(fast_if.tick);
         slow_phase_q <= slow_phase_q ^ slow_if.tick;
         core_q       <= core_d;
      end
   end

   // ---------------------------------------------------------------
   // Boot sequence
   // ---------------------------------------------------------------
   assign cal_active = (cal_s == `CLKS_CAL_DIV4) |
                       (cal_s == `CLKS_CAL_DIV8) |
                       (cal_s == `CLKS_CAL_DIV16) |
                       (cal_s == `CLKS_CAL_DIV32) |
                       (cal_s == `CLKS_CAL_SLOW);

   always_comb begin
      if (cal_s == `CLKS_CAL_DIV4) begin
         boot_mode = `CLKS_MODE_DIV4;
      end else if (cal_s == `CLKS_CAL_DIV8) begin
         boot_mode = `CLKS_MODE_DIV8;
      end else if (cal_s == `CLKS_CAL_DIV16) begin
         boot_mode = `CLKS_MODE_DIV16;
      end else if (cal_s == `CLKS_CAL_DIV32) begin
         boot_mode = `CLKS_MODE_DIV32;
      end else if (cal_s == `CLKS_CAL_SLOW) begin
         boot_mode = `CLKS_MODE_SLOW;
      end else begin
         boot_mode = mode_q;
      end
   end

   always_comb begin
      boot_d = boot_q;
      unique case (boot_q)
         clks_pkg::CLKS_BOOT_SETTLE: begin
            if (settle_q == `CLKS_SETTLE_CYCLES) begin
               boot_d = clks_pkg::CLKS_BOOT_APPLY;
            end
         end
         clks_pkg::CLKS_BOOT_APPLY: boot_d = clks_pkg::CLKS_BOOT_RUN;
         clks_pkg::CLKS_BOOT_RUN:   boot_d = clks_pkg::CLKS_BOOT_RUN;
      endcase
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Writes wait for boot so the strap load cannot override them
   assign wr_mode = reg_wr & (reg_addr == `CLKS_ADDR_MODE) & boot_done;
   assign wr_trim = reg_wr & (reg_addr == `CLKS_ADDR_TRIM) & boot_done;
   assign wr_t3c  = reg_wr & (reg_addr == `CLKS_ADDR_T3C) & boot_done;

   always_comb begin
      mode_d = mode_q;
      trim_d = trim_q;
      wdt_d  = wdt_q;
      if (boot_q == clks_pkg::CLKS_BOOT_SETTLE) begin
         // Strap picks the uncalibrated reset mode
         mode_d = fast_opt_s ? `CLKS_MODE_RST_DIV64
                             : `CLKS_MODE_RST_SLOW;
      end else if (boot_q == clks_pkg::CLKS_BOOT_APPLY) begin
         mode_d = boot_mode;
         trim_d = cal_active ? trim_s : trim_q;
         wdt_d  = ~cal_active;
      end else if (wr_mode) begin
         mode_d = reg_wdata;
      end else if (wr_trim) begin
         trim_d = reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         boot_q   <= clks_pkg::CLKS_BOOT_SETTLE;
         settle_q <= '0;
         mode_q   <= `CLKS_MODE_RST_SLOW;
         trim_q   <= `CLKS_TRIM_RESET;
         wdt_q    <= 1'b1;
         pin_in_q <= 1'b1;
         t3c_q    <= `CLKS_T3C_RESET;
      end else begin
         boot_q   <= boot_d;
         settle_q <= settle_q + 3'(boot_q == clks_pkg::CLKS_BOOT_SETTLE);
         mode_q   <= mode_d;
         trim_q   <= trim_d;
         wdt_q    <= wdt_d;
         pin_in_q <= 1'b1;
         t3c_q    <= wr_t3c ? reg_wdata[0] : t3c_q;
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   assign status = {boot_done, sel_slow, t3c_q, slow_en, fast_en,
                    core_q};

   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `CLKS_ADDR_MODE:   rdata_d = mode_q;
            `CLKS_ADDR_TRIM:   rdata_d = trim_q;
            `CLKS_ADDR_T3C:    rdata_d = {7'h00, t3c_q};
            `CLKS_ADDR_STATUS: rdata_d = {2'h0, status};
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata                   = rdata_q;
   assign core_clock                  = core_q;
   assign ultra_slow_tick             = ultra_if.tick;
   assign fast_rc_oscillator_on       = fast_en;
   assign slow_rc_oscillator_on       = slow_en;
   assign ultra_slow_rc_oscillator_on = t3c_q;
   assign watchdog_enable             = wdt_q;
   assign port_a_pin_five_input       = pin_in_q;
   assign boot_done = (boot_q == clks_pkg::CLKS_BOOT_RUN);
endmodule

// file: testbench/clks_ctrl_monitor.sv
`timescale 1ns/1ps
`include "clks_params.svh"
module clks_ctrl_monitor (
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    reset_n,
   // Register port
   input wire logic [`CLKS_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]              reg_wdata,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [7:0]              reg_rdata,
   // Straps
   input wire logic [2:0]              cal_option,
   // Outputs watched
   input wire logic                    core_clock,
   input wire logic                    ultra_slow_tick,
   input wire logic                    fast_rc_oscillator_on,
   input wire logic                    slow_rc_oscillator_on,
   input wire logic                    ultra_slow_rc_oscillator_on,
   input wire logic                    watchdog_enable,
   input wire logic                    port_a_pin_five_input,
   input wire logic                    boot_done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   sequence s_mode_wr;
      boot_done && reg_wr && reg_addr == `CLKS_ADDR_MODE;
   endsequence
   sequence s_all_off;
      s_mode_wr ##0 (!reg_wdata[4] && !reg_wdata[2]);
   endsequence
   sequence s_quiet;
      (!(reg_wr && reg_addr == `CLKS_ADDR_MODE))[*6];
   endsequence

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero without read");
   AST_UNMAPPED: assert property (reg_rd && reg_addr[2] |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_STATUS: assert property (reg_rd && reg_addr == `CLKS_ADDR_STATUS |=>
      {reg_rdata[7:5], reg_rdata[3:1]} == {2'h0, $past(boot_done),
      $past(ultra_slow_rc_oscillator_on), $past(slow_rc_oscillator_on),
      $past(fast_rc_oscillator_on)})
      else $error("status byte wrong");
   AST_FAST_EN: assert property (s_mode_wr |=>
      fast_rc_oscillator_on == $past(reg_wdata[4]))
      else $error("fast enable not from mode bit 4");
   AST_SLOW_EN: assert property (s_mode_wr |=>
      slow_rc_oscillator_on == $past(reg_wdata[2]))
      else $error("slow enable not from mode bit 2");
   AST_EN_HOLD: assert property (boot_done &&
      !(reg_wr && reg_addr == `CLKS_ADDR_MODE) |=>
      $stable(fast_rc_oscillator_on) && $stable(slow_rc_oscillator_on))
      else $error("enable changed without mode write");
   AST_ULTRA_EN: assert property (boot_done && reg_wr &&
      reg_addr == `CLKS_ADDR_T3C |=>
      ultra_slow_rc_oscillator_on == $past(reg_wdata[0]))
      else $error("ultra enable not from timer control bit 0");
   AST_ULTRA_OFF: assert property (!ultra_slow_rc_oscillator_on[*3]
      |-> !ultra_slow_tick)
      else $error("ultra tick while stopped");
   AST_FROZEN: assert property (s_all_off ##1 s_quiet |=>
      $stable(core_clock))
      else $error("core clock moves with both oscillators off");
   AST_BOOT_TIME: assert property ($rose(reset_n) |->
      !boot_done[*5] ##[1:2] boot_done)
      else $error("boot not done in time");
   AST_BOOT_STATE: assert property ($rose(boot_done) |->
      slow_rc_oscillator_on && ultra_slow_rc_oscillator_on &&
      port_a_pin_five_input && fast_rc_oscillator_on == (cal_option != 3'h5))
      else $error("oscillator state after boot wrong");
   AST_WDT: assert property (boot_done |-> watchdog_enable ==
      (cal_option == 3'h0 || cal_option > 3'h5))
      else $error("watchdog enable wrong after boot");
endmodule

bind clks_ctrl clks_ctrl_monitor u_mon (
   .clk                         (clk),
   .reset_n                     (reset_n),
   .reg_addr                    (reg_addr),
   .reg_wdata                   (reg_wdata),
   .reg_wr                      (reg_wr),
   .reg_rd                      (reg_rd),
   .reg_rdata                   (reg_rdata),
   .cal_option                  (cal_option),
   .core_clock                  (core_clock),
   .ultra_slow_tick             (ultra_slow_tick),
   .fast_rc_oscillator_on       (fast_rc_oscillator_on),
   .slow_rc_oscillator_on       (slow_rc_oscillator_on),
   .ultra_slow_rc_oscillator_on (ultra_slow_rc_oscillator_on),
   .watchdog_enable             (watchdog_enable),
   .port_a_pin_five_input       (port_a_pin_five_input),
   .boot_done                   (boot_done)
);

// file: testbench/clks_ctrl_tb.sv
`timescale 1ns/1ps
`include "clks_params.svh"
module clks_ctrl_tb;
   logic                    clk;
   logic                    reset_n;
   logic [`CLKS_ADDR_W-1:0] reg_addr;
   logic [7:0]              reg_wdata;
   logic                    reg_wr;
   logic                    reg_rd;
   logic [7:0]              reg_rdata;
   logic [2:0]              cal_option;
   logic [7:0]              cal_trim_value;
   logic                    boot_fast_option;
   logic                    core_clock;
   logic                    uticks_in;
   logic                    fast_on;
   logic                    slow_on;
   logic                    ultra_on;
   logic                    wdt_en;
   logic                    pin_in;
   logic                    boot_done;
   logic                    core_prev;
   logic [7:0]              d;
   int                      err_count;
   int                      total_checks;
   int                      cyc;
   int                      last_rise;
   int                      period;
   int                      rises;
   int                      uticks;
   int                      n;
   logic [2:0]  cal_t [7] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
   logic        bf_t [7]  = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
   logic [7:0]  mode_t [7] = '{8'hf4, 8'h54, 8'h14, 8'h3c, 8'h1c, 8'h7c,
                               8'he4};
   logic [31:0] per_t [7] = '{32'h100, 32'h100, 32'h20, 32'h40, 32'h80,
                              32'h100, 32'h100};
   logic [7:0]  sw_m [4] = '{8'h14, 8'h1c, 8'h3c, 8'h7c};
   logic [31:0] sw_p [4] = '{32'h10, 32'h40, 32'h20, 32'h80};

   clks_ctrl u_dut (
      .clk                         (clk),
      .reset_n                     (reset_n),
      .reg_addr                    (reg_addr),
      .reg_wdata                   (reg_wdata),
      .reg_wr                      (reg_wr),
      .reg_rd                      (reg_rd),
      .reg_rdata                   (reg_rdata),
      .cal_option                  (cal_option),
      .cal_trim_value              (cal_trim_value),
      .boot_fast_option            (boot_fast_option),
      .core_clock                  (core_clock),
      .ultra_slow_tick             (uticks_in),
      .fast_rc_oscillator_on       (fast_on),
      .slow_rc_oscillator_on       (slow_on),
      .ultra_slow_rc_oscillator_on (ultra_on),
      .watchdog_enable             (wdt_en),
      .port_a_pin_five_input       (pin_in),
      .boot_done                   (boot_done)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Pre-edge values are read here, so no race with the design
   always @(posedge clk) begin
      cyc++;
      if (core_clock === 1'b1 && core_prev === 1'b0) begin
         period = cyc - last_rise;
         last_rise = cyc;
         rises++;
      end
      core_prev = core_clock;
      if (uticks_in === 1'b1) uticks++;
   end

   // ---------------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr    <= 1'b0;
      // Let the write settle before anyone looks at the outputs
      @(negedge clk);
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask

   // Long wait: slowest period is 256 cycles, three fit
   task automatic meas(input logic [31:0] exp);
      repeat (800) @(posedge clk);
      check(period, exp);
   endtask

   task automatic boot(input logic [2:0] c, input logic f);
      int i;
      cal_option       <= c;
      boot_fast_option <= f;
      reset_n          <= 1'b0;
      repeat (8) @(posedge clk);
      check({fast_on, slow_on, ultra_on, wdt_en, pin_in, boot_done,
             reg_rdata}, 32'h3e00);
      reset_n <= 1'b1;
      wr(`CLKS_ADDR_MODE, 8'h00);
      i = 0;
      while (boot_done !== 1'b1 && i < 50) begin
         @(posedge clk);
         i++;
      end
      check(boot_done, 32'h1);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      $display("ERROR t=%0t watchdog expired", $time);
      end_sim;
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      // Start released so the first reset is a real falling edge
      reset_n = 1'b1;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cal_option = 3'h0;
      cal_trim_value = 8'h40;
      boot_fast_option = 1'b0;
      core_prev = 1'b0;
      for (int i = 0; i < 7; i++) begin
         boot(cal_t[i], bf_t[i]);
         rd(`CLKS_ADDR_MODE);
         check(d, mode_t[i]);
         rd(`CLKS_ADDR_TRIM);
         check(d, (i < 2) ? 8'h80 : 8'h40);
         check({wdt_en, pin_in, slow_on, ultra_on}, {i < 2, 3'h7});
         meas(per_t[i]);
         $display("test boot option %0d done", i);
      end
      // Slow to div8, old source kept on across the switch
      wr(`CLKS_ADDR_MODE, 8'hf4);
      check(fast_on, 32'h1);
      wr(`CLKS_ADDR_MODE, 8'h3c);
      meas(32'h40);
      wr(`CLKS_ADDR_MODE, 8'h38);
      check({fast_on, slow_on}, 32'h2);
      meas(32'h40);
      wr(`CLKS_ADDR_MODE, 8'h3c);
      $display("test slow to fast done");
      wr(`CLKS_ADDR_TRIM, 8'h80);
      for (int i = 0; i < 4; i++) begin
         wr(`CLKS_ADDR_MODE, sw_m[i]);
         meas(sw_p[i]);
      end
      $display("test ratio switching done");
      wr(`CLKS_ADDR_MODE, 8'hf4);
      meas(32'h100);
      wr(`CLKS_ADDR_MODE, 8'he4);
      check(fast_on, 32'h0);
      $display("test fast to slow done");
      wr(`CLKS_ADDR_MODE, 8'he0);
      repeat (20) @(posedge clk);
      n = rises;
      repeat (600) @(posedge clk);
      check(rises, n);
      wr(`CLKS_ADDR_MODE, 8'he4);
      $display("test stopped source done");
      wr(`CLKS_ADDR_T3C, 8'h00);
      check(ultra_on, 32'h0);
      repeat (4) @(posedge clk);
      n = uticks;
      repeat (1100) @(posedge clk);
      check(uticks, n);
      wr(`CLKS_ADDR_T3C, 8'h01);
      n = uticks;
      repeat (1100) @(posedge clk);
      check(uticks - n >= 2, 32'h1);
      $display("test ultra slow done");
      wr(`CLKS_ADDR_STATUS, 8'hff);
      rd(`CLKS_ADDR_STATUS);
      check(d[7:1], 32'h1e);
      rd(3'h5);
      check(d, 32'h0);
      rd(`CLKS_ADDR_MODE);
      check(d, 32'he4);
      $display("test register access done");
      end_sim;
   end
endmodule
